// ---- rtl/swc_core.sv ----
/*
  Sleep and wake controller with the two peripheral request flag registers.
  Assumes the core pulses sleep_exec for one cycle per sleep instruction and that all inputs except the asynchronous active-low resetn are synchronous to sys_clk.
*/
`timescale 1ns/1ps

// Function
// - Flags set on condition regardless of enables
// - First flag register layout, reset zero
// - Second flag register sparse, unused bits zero
// - Sleep only on sleep instruction
// - Entry clears power-down, sets time-out, stops clock
// - Entry clears watchdog; may keep counting
// - Slow oscillator keeps running in sleep
// - Timer1 keeps running on slow clocks
// - ADC runs in sleep on own oscillator
// - Pins hold drive state during sleep
// - Non-watchdog resets unaffected by sleep
// - Hard resets reset; others resume execution
// - Next instruction prefetched during sleep
// - Wake needs individual enable, ignores global
// - Wake runs next instruction, then ISR
// - Watchdog cleared on every wake
// - Pending enabled flag makes sleep a no-op
// - Late pending flag: sleep then wake immediately
// - ISR starts at fixed vector
// - Peripheral dispatch needs peripheral enable
module swc_core
  import swc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        event_one,
  input  wire logic [7:0]        event_two,
  input  wire logic              ext_irq_pending,
  input  wire logic              sleep_exec,
  input  wire logic              hard_reset_req,
  output logic                   cpu_clk_en,
  output logic                   watchdog_clear,
  output logic                   wake_req,
  output logic                   wake_resume,
  output logic                   isr_call,
  output logic [15:0]            isr_vector,
  output logic                   irq_dispatch,
  output logic                   pin_hold,
  output logic                   device_reset
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed
  {
    swc_state_e  st;
    logic [7:0]  flags_one;
    logic [7:0]  flags_two;
    logic [7:0]  int_ctrl;
    logic [7:0]  enable_one;
    logic [7:0]  enable_two;
    logic        pd;
    logic        to;
    logic        wd_clr;
    logic        resume;
    logic        isr;
    logic        rst_out;
    logic        aw_got;
    logic        w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } swc_regs_s;

  swc_regs_s r_q;
  swc_regs_s r_d;
  logic      pending;

  function automatic logic swc_mapped(input logic [ADDR_W-1:0] a);
    swc_mapped = (a[1:0] == 2'b00) && (a <= ADDR_W'(SWC_OFS_STATUS));
  endfunction

  // Next byte after a write: set beats clear so no event is lost
  function automatic logic [7:0] swc_flag_next(input logic [7:0] cur, input logic [7:0] wr,
                                               input logic hit, input logic [7:0] ev);
    logic [7:0] v;
    v = hit ? wr : cur;
    swc_flag_next = v | ev;
  endfunction

  // Enabled and pending, individual enables only, global enable ignored
  assign pending = |(r_q.flags_one & r_q.enable_one) | |(r_q.flags_two & r_q.enable_two & SWC_FLAGS_TWO_MASK)
                 | ext_irq_pending;

  always_comb
  begin
    logic wr_fire;
    logic [7:0] wb;
    wr_fire = 1'b0;
    wb      = 8'h00;
    r_d     = r_q;
    r_d.wd_clr = 1'b0;
    r_d.resume = 1'b0;
    r_d.isr    = 1'b0;
    r_d.rst_out = hard_reset_req;

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    if (s_axi_awvalid && s_axi_awready)
    begin
      r_d.aw_got  = 1'b1;
      r_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      r_d.w_got  = 1'b1;
      r_d.w_data = s_axi_wdata;
      r_d.w_strb = s_axi_wstrb;
    end
    if (r_q.aw_got && r_q.w_got && !r_q.bvalid)
    begin
      wr_fire    = swc_mapped(r_q.aw_addr) && r_q.w_strb[0];
      wb         = r_q.w_data[7:0];
      r_d.aw_got = 1'b0;
      r_d.w_got  = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp  = swc_mapped(r_q.aw_addr) ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
    end
    // Response is dropped only on the taking edge, so bresp stands until the master has seen it
    if (r_q.bvalid && s_axi_bready)
    begin
      r_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = swc_mapped(s_axi_araddr) ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_W'(SWC_OFS_FLAGS_ONE):  r_d.rdata = {24'h0000_00, r_q.flags_one};
        ADDR_W'(SWC_OFS_FLAGS_TWO):  r_d.rdata = {24'h0000_00, r_q.flags_two & SWC_FLAGS_TWO_MASK};
        ADDR_W'(SWC_OFS_INT_CTRL):   r_d.rdata = {24'h0000_00, r_q.int_ctrl};
        ADDR_W'(SWC_OFS_ENABLE_ONE): r_d.rdata = {24'h0000_00, r_q.enable_one};
        ADDR_W'(SWC_OFS_ENABLE_TWO): r_d.rdata = {24'h0000_00, r_q.enable_two & SWC_FLAGS_TWO_MASK};
        ADDR_W'(SWC_OFS_STATUS):     r_d.rdata = {29'h0000_0000, r_q.st == SWC_SLEEP, r_q.to, r_q.pd};
        default:                     r_d.rdata = 32'h0000_0000;
      endcase
    end
    else if (r_q.rvalid && s_axi_rready)
    begin
      r_d.rvalid = 1'b0;
    end

    // ************************************************************
    // Registers; flags set on every event whatever the enables
    // ************************************************************
    r_d.flags_one = swc_flag_next(r_q.flags_one, wb, wr_fire && r_q.aw_addr == ADDR_W'(SWC_OFS_FLAGS_ONE),
                                  event_one);
    r_d.flags_two = swc_flag_next(r_q.flags_two, wb, wr_fire && r_q.aw_addr == ADDR_W'(SWC_OFS_FLAGS_TWO),
                                  event_two) & SWC_FLAGS_TWO_MASK;
    if (wr_fire && r_q.aw_addr == ADDR_W'(SWC_OFS_INT_CTRL))
    begin
      r_d.int_ctrl = wb;
    end
    if (wr_fire && r_q.aw_addr == ADDR_W'(SWC_OFS_ENABLE_ONE))
    begin
      r_d.enable_one = wb;
    end
    // Unused enable bits are kept at zero so they can never raise a wake
    if (wr_fire && r_q.aw_addr == ADDR_W'(SWC_OFS_ENABLE_TWO))
    begin
      r_d.enable_two = wb & SWC_FLAGS_TWO_MASK;
    end

    // ************************************************************
    // Power sequencing
    // ************************************************************
    case (r_q.st)
      SWC_RUN:
      begin
        // Only the sleep instruction starts entry; a pending flag turns it into a no-op
        if (sleep_exec && !pending)
          r_d.st = SWC_ENTER;
      end
      SWC_ENTER:
      begin
        r_d.pd     = 1'b0;
        r_d.to     = 1'b1;
        r_d.wd_clr = 1'b1;
        // An interrupt landing during entry still clears power-down and the watchdog, then wakes at once without stopping the clock
        r_d.st     = pending ? SWC_WAKE : SWC_SLEEP;
      end
      SWC_SLEEP:
      begin
        if (pending)
          r_d.st = SWC_WAKE;
      end
      SWC_WAKE:
      begin
        r_d.wd_clr = 1'b1;
        r_d.resume = 1'b1;
        r_d.isr    = r_q.int_ctrl[SWC_GIE_BIT];
        r_d.st     = SWC_RUN;
      end
      default:
        r_d.st = SWC_RUN;
    endcase

    // Hard resets act the same asleep or awake and return to run
    if (hard_reset_req)
    begin
      r_d.st = SWC_RUN;
      r_d.pd = 1'b1;
      r_d.to = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_q      <= '0;
      r_q.st   <= SWC_RUN;
      r_q.pd   <= 1'b1;
      r_q.to   <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Clock stops only while asleep; the slow oscillator, timer1 and ADC clocks are outside this gate
  assign cpu_clk_en     = (r_q.st != SWC_SLEEP);
  assign pin_hold       = (r_q.st == SWC_SLEEP);
  assign watchdog_clear = r_q.wd_clr;
  assign wake_req       = pending;
  assign wake_resume    = r_q.resume;
  assign isr_call       = r_q.isr;
  assign isr_vector     = SWC_ISR_VECTOR;
  assign irq_dispatch   = r_q.int_ctrl[SWC_GIE_BIT] & (ext_irq_pending
                        | (r_q.int_ctrl[SWC_PERIPHERAL_IRQ_ENABLE_BIT] & pending));
  assign device_reset   = r_q.rst_out;
  assign s_axi_awready  = !r_q.aw_got && !r_q.bvalid;
  assign s_axi_wready   = !r_q.w_got && !r_q.bvalid;
  assign s_axi_bvalid   = r_q.bvalid;
  assign s_axi_bresp    = r_q.bresp;
  assign s_axi_arready  = !r_q.rvalid;
  assign s_axi_rvalid   = r_q.rvalid;
  assign s_axi_rdata    = r_q.rdata;
  assign s_axi_rresp    = r_q.rresp;

endmodule

// ---- include/swc_pkg.sv ----
/*
  Package for the sleep and wake controller: register offsets, field positions, reset values and state encodings.
  Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
*/
package swc_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] SWC_OFS_FLAGS_ONE  = 8'h00;
  localparam logic [7:0] SWC_OFS_FLAGS_TWO  = 8'h04;
  localparam logic [7:0] SWC_OFS_INT_CTRL   = 8'h08;
  localparam logic [7:0] SWC_OFS_ENABLE_ONE = 8'h0C;
  localparam logic [7:0] SWC_OFS_ENABLE_TWO = 8'h10;
  localparam logic [7:0] SWC_OFS_STATUS     = 8'h14;

  // ************************************************************
  // Fields
  // ************************************************************
  localparam logic [7:0] SWC_FLAGS_TWO_MASK = 8'h89;
  localparam int         SWC_GIE_BIT        = 7;
  localparam int         SWC_PERIPHERAL_IRQ_ENABLE_BIT       = 6;
  localparam int         SWC_PD_BIT         = 0;
  localparam int         SWC_TO_BIT         = 1;
  localparam int         SWC_SLEEP_BIT      = 2;
  localparam logic [7:0] SWC_RESET_BYTE     = 8'h00;
  localparam logic [1:0] SWC_RESP_OKAY      = 2'b00;
  localparam logic [1:0] SWC_RESP_SLVERR    = 2'b10;
  localparam logic [15:0] SWC_ISR_VECTOR    = 16'h0004;

  // ************************************************************
  // Power state, Gray coded
  // ************************************************************
  typedef enum logic [1:0]
  {
    SWC_RUN   = 2'b00,
    SWC_ENTER = 2'b01,
    SWC_SLEEP = 2'b11,
    SWC_WAKE  = 2'b10
  } swc_state_e;

endpackage

// ---- tb/swc_core_assertions.sv ----
/*
  Port checker for swc_core.
  Assumes one sys_clk domain with async active-low resetn; bound to every swc_core instance.
*/
`timescale 1ns/1ps
module swc_core_assertions
  import swc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        ext_irq_pending,
  input wire logic        sleep_exec,
  input wire logic        hard_reset_req,
  input wire logic        cpu_clk_en,
  input wire logic        watchdog_clear,
  input wire logic        wake_req,
  input wire logic        wake_resume,
  input wire logic        isr_call,
  input wire logic [15:0] isr_vector,
  input wire logic        pin_hold,
  input wire logic        device_reset
);
  // ************************************************************
  // Sleep and wake relations
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_hold_pins: assert property (!cpu_clk_en |-> pin_hold) else $error("pins not held");
  chk_fixed_vector: assert property (isr_vector == SWC_ISR_VECTOR) else $error("bad vector");
  chk_ext_wake: assert property (ext_irq_pending |-> wake_req) else $error("no wake");
  chk_noop_sleep: assert property (sleep_exec && wake_req |=> (cpu_clk_en && !watchdog_clear) [*2]) else $error("nop");
  chk_enter_clear: assert property (sleep_exec && !wake_req |-> ##[1:2] watchdog_clear) else $error("entry");
  chk_sleep_cause: assert property ($fell(cpu_clk_en) |-> $past(sleep_exec, 2)) else $error("cause");
  chk_wake_clear: assert property ($rose(cpu_clk_en) && !hard_reset_req |-> ##[0:2] (watchdog_clear && wake_resume))
    else $error("wake");
  chk_wake_rises: assert property (wake_req && !cpu_clk_en |-> ##[1:2] cpu_clk_en) else $error("stuck");
  chk_isr_gate: assert property (isr_call |-> wake_resume) else $error("isr");
  chk_hard_reset: assert property (hard_reset_req |=> device_reset) else $error("reset");
endmodule

bind swc_core swc_core_assertions chk_u (.*);

// ---- tb/swc_cpu_model.sv ----
/*
  Model of the core and the peripheral event sources.
  Assumes the bench requests sleeps and events one cycle ahead.
*/
`timescale 1ns/1ps
module swc_cpu_model
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [7:0] ev1,
  input  wire logic [7:0] ev2,
  input  wire logic       cpu_clk_en,
  output logic            sleep_exec,
  output logic [7:0]      event_one,
  output logic [7:0]      event_two
);
  // A stopped core cannot execute a sleep instruction
  always_ff @(posedge sys_clk)
  begin
    sleep_exec <= go && cpu_clk_en && resetn;
    event_one  <= ev1;
    event_two  <= ev2;
  end
endmodule

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for swc_core.
  Assumes the core model beside the block and the bound checker.
*/
`timescale 1ns/1ps
module tb_top
  import swc_pkg::*;
;
  logic        sys_clk = 1'h0, resetn = 1'h0, go = 1'h0, ext_irq_pending = 1'h0, hard_reset_req = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ev1 = 8'h00, ev2 = 8'h00, event_one, event_two;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_v, s;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_v;
  logic        sleep_exec, cpu_clk_en, watchdog_clear, wake_req, wake_resume, isr_call;
  logic        irq_dispatch, pin_hold, device_reset;
  logic [15:0] isr_vector;
  int          mismatches = 0, comparisons = 0, n;

  swc_core dut_u (.*);
  swc_cpu_model cpu_u (.*);
  initial forever #2.5 sys_clk = ~sys_clk;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] st(input logic pd, input logic to, input logic asl);
    return {29'h0000_0000, asl, to, pd};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    rd_v = s_axi_rdata;
    rresp_v = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Core only sleeps from run; four cycles covers entry
  task automatic do_sleep;
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wait_wake(input logic global_irq_enable);
    n = 0;
    while (wake_resume !== 1'h1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("wake_resume", 32'h0000_0001, wake_resume);
    chk("isr_call", global_irq_enable, isr_call);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    s = 32'h0001_0BE3;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    rd(SWC_OFS_STATUS);
    chk("status", st(1'h1, 1'h1, 1'h0), rd_v);
    rd(SWC_OFS_FLAGS_ONE);
    chk("flags_one", 32'h0000_0000, rd_v);
    rd(8'h18);
    chk("unmapped", SWC_RESP_SLVERR, rresp_v);
    for (int i = 0; i < 4; i++)
    begin
      s = lfsr(s);
      ev1 <= s[7:0];
      ev2 <= s[15:8];
      @(posedge sys_clk);
      ev1 <= 8'h00;
      ev2 <= 8'h00;
      // Model adds one stage; let the flags land before the read is taken
      @(posedge sys_clk);
      rd(SWC_OFS_FLAGS_ONE);
      chk("flags_one", {24'h00_0000, s[7:0]}, rd_v);
      rd(SWC_OFS_FLAGS_TWO);
      chk("flags_two", {24'h00_0000, s[15:8] & SWC_FLAGS_TWO_MASK}, rd_v);
      wr(SWC_OFS_FLAGS_ONE, 32'h0000_0000);
      wr(SWC_OFS_FLAGS_TWO, 32'h0000_0000);
    end
    for (int g = 0; g < 2; g++)
    begin
      s = lfsr(s);
      wr(SWC_OFS_INT_CTRL, (g == 1) ? 32'h0000_00C0 : 32'h0000_0040);
      wr(SWC_OFS_ENABLE_ONE, {24'h00_0000, s[7:0] | 8'h01});
      do_sleep();
      chk("cpu_clk_en", 32'h0000_0000, cpu_clk_en);
      rd(SWC_OFS_STATUS);
      chk("asleep", st(1'h0, 1'h1, 1'h1), rd_v);
      ev1 <= 8'h01;
      @(posedge sys_clk);
      ev1 <= 8'h00;
      wait_wake(g[0]);
      chk("dispatch", g, irq_dispatch);
      do_sleep();
      rd(SWC_OFS_STATUS);
      chk("noop", st(1'h0, 1'h1, 1'h0), rd_v);
      wr(SWC_OFS_ENABLE_ONE, 32'h0000_0000);
      wr(SWC_OFS_FLAGS_ONE, 32'h0000_0000);
    end
    do_sleep();
    hard_reset_req <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("device_reset", 32'h0000_0001, device_reset);
    hard_reset_req <= 1'h0;
    rd(SWC_OFS_STATUS);
    chk("after_reset", st(1'h1, 1'h1, 1'h0), rd_v);
    wr(SWC_OFS_INT_CTRL, 32'h0000_0000);
    wr(SWC_OFS_ENABLE_TWO, 32'h0000_0008);
    go <= 1'h1;
    ev2 <= 8'h08;
    @(posedge sys_clk);
    go <= 1'h0;
    ev2 <= 8'h00;
    wait_wake(1'h0);
    rd(SWC_OFS_STATUS);
    chk("late_pending", st(1'h0, 1'h1, 1'h0), rd_v);
    wr(SWC_OFS_ENABLE_TWO, 32'h0000_0000);
    do_sleep();
    ext_irq_pending <= 1'h1;
    wait_wake(1'h0);
    ext_irq_pending <= 1'h0;
    tally_and_finish();
  end
  // Whole run is near 200 cycles; the 10000-cycle limit allows many times that
  initial
  begin
    #50000;
    mismatches++;
    tally_and_finish();
  end
endmodule
